/* File: hdl/adc_output_port.v */
// Sample FIFO and the result port block of the converter.
// Assumes clk at 40 MHz, synchronous inputs and a host that keeps R14.
`timescale 1ns/1ps
`include "adc_port_regs.vh"

////////////////////////////////////////////////////////////////////////////
module sample_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // Drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData,
    // Fill level
    output wire [AW:0] count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    reg [AW:0] level;
    wire push;
    wire pop;

    assign inReady = (level != DEPTH[AW:0]);
    assign outValid = (level != {(AW+1){1'b0}});
    assign outData = mem[rdPtr];
    assign count = level;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            level <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : rdPtr + 1'b1;
            end
            if (push && !pop) begin
                level <= level + 1'b1;
            end else if (pop && !push) begin
                level <= level - 1'b1;
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
module adc_output_port #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Result bus pins
    input wire [15:0] resultIn,
    output reg [15:0] resultOut,
    output reg [15:0] resultOe_n,
    output reg resultValid,
    input wire resultAck,
    // Serial port pins
    input wire serialClockIn,
    output reg serialClockOut,
    output reg serialClockOe_n,
    output reg serialDataOut,
    output reg serialFrame,
    // Conversion mode
    output reg modeFast,
    output reg modeLowPower
);
    localparam ST_IDLE = 2'b01;
    localparam ST_SHIFT = 2'b10;

    reg [`CTRL_W-1:0] ctrl;
    reg haveAw;
    reg haveW;
    reg [7:0] wAddr;
    reg [31:0] wData;
    reg [3:0] wStrb;
    reg [1:0] state;
    reg [15:0] shiftReg;
    reg [4:0] bitsLeft;
    reg [3:0] halfCnt;
    reg extPrev;

    wire serialSel = ctrl[`CTRL_PORT];
    wire clockSource = resultIn[4];
    wire readMode = resultIn[7];
    wire [1:0] divSel = resultIn[3:2];
    wire writeReady = haveAw && haveW && !s_axi_bvalid;
    wire fifoInValid = writeReady && (wAddr == `OFS_SAMPLE);
    wire fifoInReady;
    wire fifoOutValid;
    wire fifoOutReady;
    wire [15:0] fifoOutData;
    wire [FIFO_AW:0] fifoCount;
    wire pop = fifoOutValid && fifoOutReady;
    wire [15:0] coded = codeWord(fifoOutData, ctrl[`CTRL_CODING]);
    wire [3:0] halfLen;
    wire extFall = extPrev && !serialClockIn;
    wire intFall = serialClockOut && (halfCnt == 4'h1);
    wire shiftEdge = clockSource ? extFall : intFall;

    // Coding of one sample
    function [15:0] codeWord;
        input [15:0] raw;
        input straight;
        begin
            codeWord = {raw[15] ^ !straight, raw[14:0]}; // R02
        end
    endfunction

    // Register read decode
    function [31:0] readMux;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_CTRL: readMux = {27'h000_0000, ctrl};
                `OFS_STATUS: readMux = {19'h0_0000, divSel, readMode,
                    clockSource, modeLowPower, modeFast, state[1],
                    !fifoInReady, fifoCount};
                `OFS_RESULT: readMux = {16'h0000, resultOut};
                default: readMux = 32'h0000_0000;
            endcase
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr == `OFS_CTRL) || (addr == `OFS_SAMPLE)
                || (addr == `OFS_STATUS) || (addr == `OFS_RESULT);
        end
    endfunction

    sample_fifo #(
        .WIDTH(`SAMPLE_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(wData[15:0]),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData),
        .count(fifoCount)
    );

    ////////////////////////////////////////////////////////////////////////
    // Drain side of the FIFO
    assign fifoOutReady = serialSel ? state[0] // R06
        : (!resultValid || resultAck);
    assign halfLen = (!clockSource && !readMode)
        ? (`SCLK_HALF_BASE << divSel) : `SCLK_HALF_BASE; // R09 R13

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            haveAw <= 1'b0;
            haveW <= 1'b0;
            wAddr <= 8'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            ctrl <= `CTRL_RESET;
        end else begin
            if (s_axi_awready && s_axi_awvalid) begin
                wAddr <= s_axi_awaddr;
                haveAw <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
                haveW <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (writeReady && (!fifoInValid || fifoInReady)) begin
                if (wAddr == `OFS_CTRL && wStrb[0]) begin
                    ctrl <= wData[`CTRL_W-1:0]; // R14
                end
                s_axi_bresp <= mapped(wAddr) ? `RESP_OKAY : `RESP_SLVERR;
                s_axi_bvalid <= 1'b1;
                haveAw <= 1'b0;
                haveW <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_rdata <= readMux(s_axi_araddr);
                s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY
                    : `RESP_SLVERR;
                s_axi_rvalid <= 1'b1;
                s_axi_arready <= 1'b0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion mode and pin direction
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            modeFast <= 1'b0;
            modeLowPower <= 1'b0;
            resultOe_n <= 16'hFFFF;
            serialClockOe_n <= 1'b1;
        end else begin
            modeFast <= ctrl[`CTRL_FAST] && !ctrl[`CTRL_LOWPWR]; // R03 R04
            modeLowPower <= ctrl[`CTRL_LOWPWR] && !ctrl[`CTRL_FAST]; // R05
            // Serial floats all shared pins, parallel drives them all
            resultOe_n <= serialSel ? 16'hFFFF : 16'h0000; // R06 R07 R08 R10
            serialClockOe_n <= !(serialSel && !clockSource); // R11 R12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parallel holding register
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resultOut <= 16'h0000;
            resultValid <= 1'b0;
        end else if (!serialSel) begin
            if (pop) begin
                resultOut <= ctrl[`CTRL_SWAP] ? {coded[7:0], coded[15:8]}
                    : coded; // R01
                resultValid <= 1'b1;
            end else if (resultAck) begin
                resultValid <= 1'b0;
            end
        end else begin
            resultValid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial shifter, MSB first, data changes on falling clock edge
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            shiftReg <= 16'h0000;
            bitsLeft <= 5'h00;
            halfCnt <= 4'h0;
            serialClockOut <= 1'b0;
            serialDataOut <= 1'b0;
            serialFrame <= 1'b0;
            extPrev <= 1'b0;
        end else begin
            extPrev <= serialClockIn; // R12
            case (state)
                ST_IDLE: begin
                    serialClockOut <= 1'b0;
                    if (serialSel && pop) begin
                        shiftReg <= coded;
                        serialDataOut <= coded[15];
                        bitsLeft <= `SAMPLE_BITS;
                        halfCnt <= halfLen;
                        serialFrame <= 1'b1;
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (!clockSource) begin
                        if (halfCnt == 4'h1) begin
                            halfCnt <= halfLen; // R09
                            serialClockOut <= !serialClockOut; // R11
                        end else begin
                            halfCnt <= halfCnt - 4'h1;
                        end
                    end
                    if (shiftEdge) begin
                        shiftReg <= {shiftReg[14:0], 1'b0};
                        serialDataOut <= shiftReg[14];
                        bitsLeft <= bitsLeft - 5'h01;
                        if (bitsLeft == 5'h01) begin
                            serialFrame <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: hdl/adc_port_regs.vh */
// Register map, field positions, reset values and timing of the port block.
// Assumes a 32-bit AXI4-Lite bus with byte addresses on aligned words.
//
// Overview of operation
// R01 - Byte order select swaps the parallel result bytes
// R02 - Coding select low inverts MSB, two's complement
// R03 - Fast mode; host keeps a minimum conversion rate
// R04 - Fast mode off imposes no minimum conversion rate
// R05 - Low-power mode without fast mode selects reduced power
// R06 - Port type selects parallel bus or serial port
// R07 - Serial mode floats result bits zero and one
// R08 - Parallel mode drives result bits two to four
// R09 - Serial internal read-after mode allows clock slowdown
// R10 - Other serial modes float the divide pins
// R11 - Internal clock source drives serial clock out
// R12 - External clock source: host clocks, device follows
// R13 - Read mode high shifts during, low after conversion
// R14 - Host changes selects only between conversions
`ifndef ADC_PORT_REGS_VH
`define ADC_PORT_REGS_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SAMPLE 8'h04
`define OFS_STATUS 8'h08
`define OFS_RESULT 8'h0C

// Control register fields
`define CTRL_W 5
`define CTRL_PORT 0
`define CTRL_SWAP 1
`define CTRL_CODING 2
`define CTRL_FAST 3
`define CTRL_LOWPWR 4
`define CTRL_RESET 5'h04

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Serial clock half period in clk cycles before slowdown
`define SCLK_HALF_BASE 4'h1
`define SAMPLE_W 16
`define SAMPLE_BITS 5'h10

`endif

/* File: tb/adc_port_monitor.sv */
// Checker on the result pins, the modes and the write answer.
// Assumes a bind to adc_output_port and a host that holds its selects.
`timescale 1ns/1ps
module adc_port_monitor (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Bus answer
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Result pins
    input wire [15:0] resultIn,
    input wire [15:0] resultOut,
    input wire [15:0] resultOe_n,
    input wire resultValid,
    input wire resultAck,
    // Serial pins
    input wire serialClockOut,
    input wire serialClockOe_n,
    input wire serialDataOut,
    input wire serialFrame,
    // Modes
    input wire modeFast,
    input wire modeLowPower
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_mode_excl: assert property (!(modeFast && modeLowPower))
        else $error("fast and low power together");
    a_word_hold: assert property (resultValid && !resultAck |=>
        resultValid && $stable(resultOut)) else $error("word lost");
    a_ser_float: assert property (serialFrame |-> &resultOe_n[1:0])
        else $error("bits 0 1 driven in serial");
    a_div_float: assert property (serialFrame |-> &resultOe_n[3:2])
        else $error("divide pins driven");
    a_par_drive: assert property (resultValid |-> !(|resultOe_n[4:2]))
        else $error("bits 2 to 4 not driven");
    a_int_clock: assert property (serialFrame && !resultIn[4] |->
        !serialClockOe_n) else $error("clock not driven");
    a_ext_clock: assert property (serialFrame && resultIn[4] |->
        serialClockOe_n) else $error("clock driven in external mode");
    a_data_fall: assert property (serialFrame && !resultIn[4] &&
        $rose(serialClockOut) |-> $stable(serialDataOut))
        else $error("data moved on rising clock");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write answer dropped");
endmodule
bind adc_output_port adc_port_monitor i_adc_port_monitor (.clk, .sys_rst,
    .s_axi_bvalid, .s_axi_bready, .resultIn, .resultOut, .resultOe_n,
    .resultValid, .resultAck, .serialClockOut, .serialClockOe_n,
    .serialDataOut, .serialFrame, .modeFast, .modeLowPower);

/* File: tb/host_model.sv */
// Host model: takes parallel words, clocks and receives serial words.
// Assumes the same clk as the port block.
`timescale 1ns/1ps
module host_model (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Parallel port
    input wire resultValid,
    output logic resultAck,
    input wire [15:0] resultOut,
    input wire stall,
    // Serial port
    input wire serialFrame,
    input wire serialClockOut,
    input wire serialDataOut,
    output logic serialClockIn,
    input wire extClk
);
    logic [15:0] words [0:63];
    logic [15:0] shift;
    logic [1:0] gap, div;
    logic prevClk, prevFrame;
    int n;
    wire bitClk = extClk ? serialClockIn : serialClockOut;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            n <= 0;
            gap <= 2'h0;
            div <= 2'h0;
            resultAck <= 1'b0;
            serialClockIn <= 1'b0;
            prevClk <= 1'b0;
            prevFrame <= 1'b0;
        end else begin
            resultAck <= resultValid && !resultAck && !stall && !gap;
            if (resultAck)
                gap <= 2'h2;
            else if (gap != 2'h0)
                gap <= gap - 2'h1;
            div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
            if (!serialFrame)
                serialClockIn <= 1'b0;
            else if (extClk && div == 2'h2)
                serialClockIn <= !serialClockIn;
            prevClk <= bitClk;
            prevFrame <= serialFrame;
            if (serialFrame && bitClk && !prevClk)
                shift <= {shift[14:0], serialDataOut};
            if (resultValid && resultAck) begin
                words[n] <= resultOut;
                n <= n + 1;
            end else if (prevFrame && !serialFrame) begin
                words[n] <= shift;
                n <= n + 1;
            end
        end
    end
endmodule

/* File: tb/tb_top.sv */
// Bench for the result port: registers, parallel, FIFO and serial.
// Assumes host_model and the checker are compiled first.
`timescale 1ns/1ps
`include "adc_port_regs.vh"
module tb_top;
    logic clk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic stall = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, hp = 0;
    logic [31:0] s_axi_wdata = 0, d, seed = 32'h258e_fbe7;
    logic [1:0] r;
    logic [15:0] raw, q[$];
    logic [7:0] modes [4] = '{8'h00, 8'h04, 8'h80, 8'h10};
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, resultValid, resultAck, serialClockIn;
    wire serialClockOut, serialClockOe_n, serialDataOut, serialFrame;
    wire modeFast, modeLowPower;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] resultOut, resultOe_n;
    wire [15:0] resultIn = (~resultOe_n & resultOut) |
        (resultOe_n & {8'h00, hp});
    int failures = 0, numChecks = 0, cyc = 0, k, cnt = 0;

    adc_output_port i_adc_output_port (.clk, .sys_rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .resultIn,
        .resultOut, .resultOe_n, .resultValid, .resultAck, .serialClockIn,
        .serialClockOut, .serialClockOe_n, .serialDataOut, .serialFrame,
        .modeFast, .modeLowPower);
    host_model i_host_model (.clk, .sys_rst, .resultValid, .resultAck,
        .resultOut, .stall, .serialFrame, .serialClockOut, .serialDataOut,
        .serialClockIn, .extClk(hp[4]));

    ////////////////////////////////////////////////////////////////////////
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            finish_test;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [15:0] expPar(input logic [15:0] v,
        input logic sw, input logic cd);
        v = cd ? v : v ^ 16'h8000;
        return sw ? {v[7:0], v[15:8]} : v;
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        forever begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 0;
                break;
            end
        end
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        forever begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 0;
                break;
            end
        end
    endtask
    task push;
        seed = xs(seed);
        raw = seed[15:0];
        wr(`OFS_SAMPLE, {16'h0000, raw});
    endtask
    task waitN(input int m);
        for (int i = 0; i < 3000 && i_host_model.n < m; i++) @(posedge clk);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        rd(`OFS_CTRL);
        chk("ctrl", 32'h0000_0004, d);
        chk("oe", 16'h0000, resultOe_n);
        rd(8'h10);
        chk("rresp", `RESP_SLVERR, r);
        wr(8'h10, 32'h0000_0001);
        chk("bresp", `RESP_SLVERR, r);
        $display("test registers done");
        for (k = 0; k < 4; k++) begin
            wr(`OFS_CTRL, k << 1);
            push;
            waitN(cnt + 1);
            chk("par", expPar(raw, k[0], k[1]),
                i_host_model.words[cnt]);
            cnt++;
        end
        rd(`OFS_RESULT);
        chk("result", {16'h0000, expPar(raw, 1'b1, 1'b1)}, d);
        $display("test parallel done");
        for (k = 0; k < 4; k++) begin
            wr(`OFS_CTRL, 4 | (k << 3));
            repeat (2) @(posedge clk);
            chk("fast", k == 1, modeFast);
            chk("lowpower", k == 2, modeLowPower);
        end
        $display("test modes done");
        stall <= 1;
        for (k = 0; k < 17; k++) begin
            push;
            q.push_back(raw);
        end
        rd(`OFS_STATUS);
        chk("full", 6'h30, d[5:0]);
        stall <= 0;
        waitN(cnt + 17);
        for (k = 0; k < 17; k++)
            chk("drain", q[k], i_host_model.words[cnt + k]);
        cnt += 17;
        $display("test buffer done");
        for (k = 0; k < 4; k++) begin
            hp <= modes[k];
            wr(`OFS_CTRL, 32'h0000_0005);
            repeat (2) @(posedge clk);
            chk("oe01", 2'b11, resultOe_n[1:0]);
            chk("oediv", 2'b11, resultOe_n[3:2]);
            rd(`OFS_STATUS);
            chk("pins", {modes[k][3:2], modes[k][7], modes[k][4]},
                d[12:9]);
            push;
            waitN(cnt + 1);
            chk("serial", raw, i_host_model.words[cnt]);
            cnt++;
        end
        $display("test serial done");
        finish_test;
    end
endmodule
